// >>> shared/rfd_consts.svh
`ifndef RFD_CONSTS_SVH
`define RFD_CONSTS_SVH

// Field positions in the 16-bit instruction word
`define RFD_OP_HI      15
`define RFD_OP_LO      12
`define RFD_RN_HI      11
`define RFD_RN_LO      8
`define RFD_RM_HI      7
`define RFD_RM_LO      4
`define RFD_D4_HI      3
`define RFD_D4_LO      0

// Major opcodes, bits 15:12
`define RFD_OP_NM      4'h0
`define RFD_OP_NMD     4'h1
`define RFD_OP_MD      4'h2
`define RFD_OP_ND8     4'h3
`define RFD_OP_D12     4'h4
`define RFD_OP_I       4'h5
`define RFD_OP_NI_ADD  4'h6
`define RFD_OP_NI_MOV  4'h7
`define RFD_OP_NI_CMP  4'h8

// Sub-opcodes of the register-register group, bits 3:0
`define RFD_SUB_SWAP   4'h0
`define RFD_SUB_ADD_CY 4'h1
`define RFD_SUB_ADD_OV 4'h2
`define RFD_SUB_XTR    4'h3
`define RFD_SUB_ACC    4'h4

// Sub-opcodes of the immediate-only group, bits 11:8
`define RFD_ISUB_GLOB  4'h0
`define RFD_ISUB_LOGIC 4'h1
`define RFD_ISUB_TRAP  4'h2
`define RFD_ISUB_MOV   4'h3

`endif

// >>> shared/rfd_pkg.sv
package rfd_pkg;

    typedef enum logic [3:0] {
        RFD_FMT_NONE = 4'h0,
        RFD_FMT_NM   = 4'h1,
        RFD_FMT_NMD  = 4'h2,
        RFD_FMT_MD   = 4'h3,
        RFD_FMT_ND8  = 4'h4,
        RFD_FMT_D12  = 4'h5,
        RFD_FMT_I    = 4'h6,
        RFD_FMT_NI   = 4'h7
    } rfd_fmt_e;

    typedef struct packed {
        logic        valid;
        rfd_fmt_e    fmt;
        logic [3:0]  dst_reg;
        logic [3:0]  src_reg;
        logic [3:0]  src2_reg;
        logic        dst_we;
        logic        src_postinc;
        logic        src2_postinc;
        logic        acc_write;
        logic [11:0] disp;
        logic [31:0] imm;
        logic        use_global;
        logic        use_reg_zero;
        logic        trap;
        logic [31:0] trap_offset;
        logic [31:0] branch_target;
        logic [31:0] result;
        logic        cond_we;
        logic        cond_bit;
        logic        illegal;
    } rfd_state_s;

endpackage : rfd_pkg

// >>> shared/rfd_if.sv
`timescale 1ns/1ps

interface rfd_if;
    logic [15:0] instr;
    logic [3:0]  op;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic [3:0]  d4;
    logic [7:0]  low8;
    logic [11:0] d12;

    modport split (
        input  instr,
        output op,
        output rn,
        output rm,
        output d4,
        output low8,
        output d12
    );

    modport dec (
        output instr,
        input  op,
        input  rn,
        input  rm,
        input  d4,
        input  low8,
        input  d12
    );
endinterface : rfd_if

// >>> verilog/rfd_field_split.sv
`timescale 1ns/1ps
`include "rfd_consts.svh"

module rfd_field_split (
    rfd_if.split bus
);
    assign bus.op   = bus.instr[`RFD_OP_HI:`RFD_OP_LO];
    assign bus.rn   = bus.instr[`RFD_RN_HI:`RFD_RN_LO];
    assign bus.rm   = bus.instr[`RFD_RM_HI:`RFD_RM_LO];
    assign bus.d4   = bus.instr[`RFD_D4_HI:`RFD_D4_LO];
    assign bus.low8 = bus.instr[`RFD_RM_HI:`RFD_D4_LO];
    assign bus.d12  = bus.instr[`RFD_RN_HI:`RFD_D4_LO];
endmodule : rfd_field_split

// >>> verilog/rfd_decoder.sv
`timescale 1ns/1ps
`include "rfd_consts.svh"

module rfd_decoder (
    input  wire logic           i_mclk,
    input  wire logic           i_rst_b,
    input  wire logic           i_instr_valid,
    input  wire logic [15:0]    i_instr,
    input  wire logic [31:0]    i_pc,
    input  wire logic [31:0]    i_rn_value,
    input  wire logic [31:0]    i_rm_value,
    input  wire logic           i_carry,
    output logic                o_valid,
    output rfd_pkg::rfd_fmt_e   o_format,
    output logic [3:0]          o_dst_reg,
    output logic [3:0]          o_src_reg,
    output logic [3:0]          o_src2_reg,
    output logic                o_dst_we,
    output logic                o_src_postinc,
    output logic                o_src2_postinc,
    output logic                o_acc_write,
    output logic [11:0]         o_disp,
    output logic [31:0]         o_imm,
    output logic                o_use_global,
    output logic                o_use_reg_zero,
    output logic                o_trap,
    output logic [31:0]         o_trap_offset,
    output logic [31:0]         o_branch_target,
    output logic [31:0]         o_result,
    output logic                o_cond_we,
    output logic                o_cond_bit,
    output logic                o_illegal
);

    rfd_if                fld ();
    rfd_pkg::rfd_state_s  s;
    rfd_pkg::rfd_state_s  next_s;

    assign fld.instr = i_instr;

    rfd_field_split u_split (
        .bus (fld.split)
    );

    function automatic logic [31:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction : sext8

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction : zext8

    always_comb begin
        logic [32:0] sum;
        logic [31:0] sext12;
        sum    = 33'h000000000;
        sext12 = 32'h00000000;
        next_s = s;
        next_s.valid = i_instr_valid;
        if (i_instr_valid) begin
            next_s.fmt          = rfd_pkg::RFD_FMT_NONE;
            next_s.dst_reg      = 4'h0;
            next_s.src_reg      = 4'h0;
            next_s.src2_reg     = 4'h0;
            next_s.dst_we       = 1'b0;
            next_s.src_postinc  = 1'b0;
            next_s.src2_postinc = 1'b0;
            next_s.acc_write    = 1'b0;
            next_s.disp         = 12'h000;
            next_s.imm          = 32'h00000000;
            next_s.use_global   = 1'b0;
            next_s.use_reg_zero = 1'b0;
            next_s.trap         = 1'b0;
            next_s.trap_offset  = 32'h00000000;
            next_s.branch_target = 32'h00000000;
            next_s.result       = 32'h00000000;
            next_s.cond_we      = 1'b0;
            next_s.cond_bit     = 1'b0;
            next_s.illegal      = 1'b0;
            unique case (fld.op)
                `RFD_OP_NM: begin
                    next_s.fmt     = rfd_pkg::RFD_FMT_NM;
                    next_s.dst_reg = fld.rn;
                    next_s.src_reg = fld.rm;
                    unique case (fld.d4)
                        `RFD_SUB_SWAP: begin
                            next_s.dst_we = 1'b1;
                            next_s.result = {i_rm_value[31:16], i_rm_value[7:0], i_rm_value[15:8]};
                        end
                        `RFD_SUB_ADD_CY: begin
                            sum = {1'b0, i_rn_value} + {1'b0, i_rm_value} + {32'h00000000, i_carry};
                            next_s.dst_we   = 1'b1;
                            next_s.result   = sum[31:0];
                            next_s.cond_we  = 1'b1;
                            next_s.cond_bit = sum[32];
                        end
                        `RFD_SUB_ADD_OV: begin
                            sum = {1'b0, i_rn_value} + {1'b0, i_rm_value};
                            next_s.dst_we   = 1'b1;
                            next_s.result   = sum[31:0];
                            next_s.cond_we  = 1'b1;
                            next_s.cond_bit = (i_rn_value[31] == i_rm_value[31])
                                              && (sum[31] != i_rn_value[31]);
                        end
                        `RFD_SUB_XTR: begin
                            next_s.dst_we = 1'b1;
                            next_s.result = {i_rm_value[15:0], i_rn_value[31:16]};
                        end
                        `RFD_SUB_ACC: begin
                            next_s.dst_reg      = 4'h0;
                            next_s.src2_reg     = fld.rn;
                            next_s.src_postinc  = 1'b1;
                            next_s.src2_postinc = 1'b1;
                            next_s.acc_write    = 1'b1;
                        end
                        default: begin
                            next_s.illegal = 1'b1;
                        end
                    endcase
                end
                `RFD_OP_NMD: begin
                    next_s.fmt     = rfd_pkg::RFD_FMT_NMD;
                    next_s.dst_reg = fld.rn;
                    next_s.src_reg = fld.rm;
                    next_s.disp    = {8'h00, fld.d4};
                end
                `RFD_OP_MD: begin
                    next_s.fmt          = rfd_pkg::RFD_FMT_MD;
                    next_s.src_reg      = fld.rm;
                    next_s.disp         = {8'h00, fld.d4};
                    next_s.use_reg_zero = 1'b1;
                end
                `RFD_OP_ND8: begin
                    next_s.fmt     = rfd_pkg::RFD_FMT_ND8;
                    next_s.dst_reg = fld.rn;
                    next_s.disp    = {4'h0, fld.low8};
                end
                `RFD_OP_D12: begin
                    next_s.fmt  = rfd_pkg::RFD_FMT_D12;
                    next_s.disp = fld.d12;
                    sext12 = {{20{fld.d12[11]}}, fld.d12};
                    next_s.branch_target = i_pc + {sext12[30:0], 1'b0};
                end
                `RFD_OP_I: begin
                    next_s.fmt = rfd_pkg::RFD_FMT_I;
                    unique case (fld.rn)
                        `RFD_ISUB_GLOB: begin
                            next_s.use_global   = 1'b1;
                            next_s.use_reg_zero = 1'b1;
                            next_s.imm          = zext8(fld.low8);
                        end
                        `RFD_ISUB_LOGIC: begin
                            next_s.use_reg_zero = 1'b1;
                            next_s.imm          = zext8(fld.low8);
                        end
                        `RFD_ISUB_TRAP: begin
                            next_s.trap        = 1'b1;
                            next_s.imm         = zext8(fld.low8);
                            next_s.trap_offset = {22'h0, fld.low8, 2'b00};
                        end
                        `RFD_ISUB_MOV: begin
                            next_s.use_reg_zero = 1'b1;
                            next_s.dst_we       = 1'b1;
                            next_s.imm          = sext8(fld.low8);
                        end
                        default: begin
                            next_s.illegal = 1'b1;
                        end
                    endcase
                end
                `RFD_OP_NI_ADD, `RFD_OP_NI_MOV, `RFD_OP_NI_CMP: begin
                    next_s.fmt     = rfd_pkg::RFD_FMT_NI;
                    next_s.dst_reg = fld.rn;
                    next_s.imm     = sext8(fld.low8);
                    next_s.dst_we  = (fld.op != `RFD_OP_NI_CMP);
                    next_s.cond_we = (fld.op == `RFD_OP_NI_CMP);
                    next_s.cond_bit = (fld.op == `RFD_OP_NI_CMP) && (i_rn_value == sext8(fld.low8));
                    next_s.result  = (fld.op == `RFD_OP_NI_ADD) ? i_rn_value + sext8(fld.low8)
                                                                : sext8(fld.low8);
                end
                default: begin
                    next_s.illegal = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_valid         = s.valid;
    assign o_format        = s.fmt;
    assign o_dst_reg       = s.dst_reg;
    assign o_src_reg       = s.src_reg;
    assign o_src2_reg      = s.src2_reg;
    assign o_dst_we        = s.dst_we;
    assign o_src_postinc   = s.src_postinc;
    assign o_src2_postinc  = s.src2_postinc;
    assign o_acc_write     = s.acc_write;
    assign o_disp          = s.disp;
    assign o_imm           = s.imm;
    assign o_use_global    = s.use_global;
    assign o_use_reg_zero  = s.use_reg_zero;
    assign o_trap          = s.trap;
    assign o_trap_offset   = s.trap_offset;
    assign o_branch_target = s.branch_target;
    assign o_result        = s.result;
    assign o_cond_we       = s.cond_we;
    assign o_cond_bit      = s.cond_bit;
    assign o_illegal       = s.illegal;

endmodule : rfd_decoder

// >>> test/rfd_props.sv
`timescale 1ns/1ps
module rfd_props (
    input wire logic              i_mclk,
    input wire logic              i_rst_b,
    input wire logic              i_instr_valid,
    input wire logic [15:0]       i_instr,
    input wire logic [31:0]       i_pc,
    input wire logic              o_valid,
    input wire rfd_pkg::rfd_fmt_e o_format,
    input wire logic [3:0]        o_src2_reg,
    input wire logic              o_dst_we,
    input wire logic              o_acc_write,
    input wire logic [11:0]       o_disp,
    input wire logic [31:0]       o_imm,
    input wire logic [31:0]       o_trap_offset,
    input wire logic [31:0]       o_branch_target
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    sequence s_op(logic [3:0] op);
        i_instr_valid && i_instr[15:12] == op;
    endsequence
    sequence s_nm_sub(logic [3:0] sub);
        i_instr_valid && i_instr[15:12] == 4'h0 && i_instr[3:0] == sub;
    endsequence
    sequence s_isub(logic [3:0] sub);
        i_instr_valid && i_instr[15:8] == {4'h5, sub};
    endsequence
    a_nmd_fields:
        assert property (s_op(4'h1) |=> o_format == rfd_pkg::RFD_FMT_NMD && o_disp == {8'h0, $past(i_instr[3:0])})
        else $error("nmd fields wrong");
    a_global_zext:
        assert property (s_isub(4'h0) |=> o_imm == {24'h0, $past(i_instr[7:0])}) else $error("global imm wrong");
    a_logic_zext:
        assert property (s_isub(4'h1) |=> o_imm == {24'h0, $past(i_instr[7:0])}) else $error("logic imm wrong");
    a_ni_sext:
        assert property (s_op(4'h6) |=> o_dst_we && o_imm == {{24{$past(i_instr[7])}}, $past(i_instr[7:0])})
        else $error("add imm wrong");
    a_acc_roles:
        assert property (s_nm_sub(4'h4) |=> o_acc_write && !o_dst_we
            && o_src2_reg == $past(i_instr[11:8])) else $error("accumulate roles wrong");
    a_md_disp:
        assert property (s_op(4'h2) |=> o_format == rfd_pkg::RFD_FMT_MD && o_disp == {8'h0, $past(i_instr[3:0])})
        else $error("md disp wrong");
    a_branch_target:
        assert property (s_op(4'h4) |=> o_branch_target
            == $past(i_pc) + {{19{$past(i_instr[11])}}, $past(i_instr[11:0]), 1'b0}) else $error("target wrong");
    a_trap_offset:
        assert property (s_isub(4'h2) |=> o_trap_offset == {22'h0, $past(i_instr[7:0]), 2'b00})
        else $error("trap offset wrong");
    a_idle_hold:
        assert property (!i_instr_valid |=> !o_valid && $stable(o_disp) && $stable(o_imm)) else $error("idle hold");
endmodule : rfd_props
bind rfd_decoder rfd_props u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_pc(i_pc), .o_valid(o_valid), .o_format(o_format), .o_src2_reg(o_src2_reg),
    .o_dst_we(o_dst_we), .o_acc_write(o_acc_write), .o_disp(o_disp), .o_imm(o_imm),
    .o_trap_offset(o_trap_offset), .o_branch_target(o_branch_target));

// >>> test/rfd_fetch_model.sv
`timescale 1ns/1ps
module rfd_fetch_model (
    input  wire logic        i_mclk,
    input  wire logic        i_send,
    input  wire logic [15:0] i_word,
    output logic             o_instr_valid,
    output logic [15:0]      o_instr
);
    logic [15:0] last = 16'h0;
    always_ff @(posedge i_mclk) begin
        if (i_send) begin
            last <= i_word;
        end
    end
    // Idle bus shows no stale word
    assign o_instr_valid = i_send;
    assign o_instr       = i_send ? i_word : ~last;
endmodule : rfd_fetch_model

// >>> test/rfd_decoder_tb.sv
`timescale 1ns/1ps
module rfd_decoder_tb;
    logic              i_mclk = 1'b0;
    logic              i_rst_b = 1'b0;
    logic              send = 1'b0;
    logic              carry = 1'b0;
    logic [15:0]       word = 16'h0;
    logic [15:0]       instr;
    logic [31:0]       pc = 32'h0, rn = 32'h0, rm = 32'h0;
    logic [31:0]       imm, toff, btgt, res;
    logic [11:0]       disp;
    logic [3:0]        dst, src, src2;
    logic              vld, ovld, dwe, pi1, pi2, accw, glb, rz, trap, cwe, cbit, ill;
    rfd_pkg::rfd_fmt_e fmt;
    int                fail_count = 0, total_checks = 0, cycles = 0;
    always #5 i_mclk = ~i_mclk;
    rfd_fetch_model u_fetch (.i_mclk(i_mclk), .i_send(send), .i_word(word), .o_instr_valid(vld), .o_instr(instr));
    rfd_decoder DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_instr_valid(vld), .i_instr(instr), .i_pc(pc),
        .i_rn_value(rn), .i_rm_value(rm), .i_carry(carry), .o_valid(ovld), .o_format(fmt), .o_dst_reg(dst),
        .o_src_reg(src), .o_src2_reg(src2), .o_dst_we(dwe), .o_src_postinc(pi1), .o_src2_postinc(pi2),
        .o_acc_write(accw), .o_disp(disp), .o_imm(imm), .o_use_global(glb), .o_use_reg_zero(rz), .o_trap(trap),
        .o_trap_offset(toff), .o_branch_target(btgt), .o_result(res), .o_cond_we(cwe), .o_cond_bit(cbit),
        .o_illegal(ill));
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic issue(input logic [15:0] w, input logic [31:0] a, input logic [31:0] b,
                         input logic c = 1'b0, input logic [31:0] p = 32'h1000);
        @(posedge i_mclk);
        send  <= 1'b1;
        word  <= w;
        rn    <= a;
        rm    <= b;
        carry <= c;
        pc    <= p;
        @(posedge i_mclk);
        send <= 1'b0;
        #1;
    endtask : issue
    task automatic t_fields;
        issue(16'h1a5c, 0, 0);
        chk({28'h0, rfd_pkg::RFD_FMT_NMD}, {28'h0, fmt});
        chk(32'ha500c, {12'h0, dst, src, disp});
        chk(32'h1, {31'h0, ovld});
        @(posedge i_mclk);
        #1;
        chk(32'h0000c, {19'h0, ovld, disp});
        issue(16'h2a37, 0, 0);
        chk(32'h3007, {16'h0, src, disp});
        issue(16'h3b9c, 0, 0);
        chk(32'hb09c, {16'h0, dst, disp});
        issue(16'hf000, 0, 0);
        chk(32'h1, {31'h0, ill});
        issue(16'h0125, 0, 0);
        chk(32'h1, {31'h0, ill});
        issue(16'h5400, 0, 0);
        chk(32'h1, {31'h0, ill});
        $display("fields test done");
    endtask : t_fields
    task automatic t_imm;
        logic [15:0] w [6] = '{16'h6b80, 16'h7c7f, 16'h8390, 16'h51f0, 16'h50c4, 16'h5381};
        logic [31:0] e [6] = '{32'hffffff80, 32'h7f, 32'hffffff90, 32'hf0, 32'hc4, 32'hffffff81};
        logic [1:0]  f [6] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b11, 2'b01};
        for (int i = 0; i < 6; i++) begin
            issue(w[i], 32'h100, 0);
            chk(e[i], imm);
            chk({30'h0, f[i]}, {30'h0, glb, rz});
        end
        issue(16'h6b80, 32'h100, 0);
        chk(32'hb80, {20'h0, dst, res[7:0]});
        chk(32'h1, {31'h0, dwe});
        issue(16'h8390, 32'hffffff90, 0);
        chk(32'h3, {30'h0, cwe, cbit});
        issue(16'h52ff, 0, 0);
        chk(32'h1, {31'h0, trap});
        chk(32'h3fc, toff);
        $display("immediate test done");
    endtask : t_imm
    task automatic t_branch;
        issue(16'h4800, 0, 0);
        chk(32'h0, btgt);
        issue(16'h47ff, 0, 0);
        chk(32'h1ffe, btgt);
        $display("branch test done");
    endtask : t_branch
    task automatic t_regreg;
        issue(16'h0120, 0, 32'h12345678);
        chk(32'h12347856, res);
        chk(32'h3, {27'h0, dst, dwe});
        issue(16'h0121, 32'hffffffff, 32'h1, 1'b1);
        chk(32'h1, res);
        chk(32'h3, {30'h0, cwe, cbit});
        issue(16'h0122, 32'h7fffffff, 32'h1);
        chk(32'h80000000, res);
        chk(32'h3, {30'h0, cwe, cbit});
        issue(16'h0122, 32'h1, 32'h1);
        chk(32'h2, {30'h0, cwe, cbit});
        issue(16'h0123, 32'haaaabbbb, 32'hccccdddd);
        chk(32'hddddaaaa, res);
        issue(16'h0a54, 0, 0);
        chk(32'hb5a, {20'h0, accw, dwe, pi1, pi2, src, src2});
        $display("register test done");
    endtask : t_regreg
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            test_done;
        end
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_fields;
        t_imm;
        t_branch;
        t_regreg;
        test_done;
    end
endmodule : rfd_decoder_tb
